//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
  import fecc_pkg::*;

  typedef struct {
    logic [7:0] din;
    logic [2:0] f;
    logic [2:0] s;
    logic       e1;
    logic       e2;
  } fecc_row_s;

  logic                 clock;
  logic                 rst_n;
  logic [7:0]           addr;
  logic [7:0]           wr_data;
  logic                 wr_stb;
  logic                 rd_stb;
  logic [7:0]           rd_data;
  logic                 enc_bit_in;
  logic                 enc_bit_valid;
  logic [15:0]          ber_result;
  logic                 ber_update;
  logic                 phase_sync_en;
  fecc_soft_t           soft_in_first;
  fecc_soft_t           soft_in_second;
  fecc_soft_t           soft_in_third;
  logic                 erase_first;
  logic                 erase_second;
  logic                 erase_third;
  logic                 punct_sync;
  logic                 symbols_valid;
  logic                 serial_mode;
  logic                 oqpsk_active;
  logic [3:0]           rate_enable;
  logic                 soft_notation_select;
  int                   n_errors;
  int                   n_checks;
  int                   cycles = 0;
  logic [7:0]           d;
  int                   ones;
  int                   toggles;
  fecc_row_s            rows [5];

  fecc_regport dut_u (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .rd_data(rd_data), .enc_bit_in(enc_bit_in),
    .enc_bit_valid(enc_bit_valid), .ber_result(ber_result), .ber_update(ber_update),
    .phase_sync_en(phase_sync_en), .soft_in_first(soft_in_first),
    .soft_in_second(soft_in_second), .soft_in_third(soft_in_third),
    .erase_first(erase_first), .erase_second(erase_second), .erase_third(erase_third),
    .punct_sync(punct_sync), .symbols_valid(symbols_valid), .serial_mode(serial_mode),
    .oqpsk_active(oqpsk_active), .rate_enable(rate_enable),
    .soft_notation_select(soft_notation_select)
  );

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard: the full sequence needs well under a thousand cycles
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Outputs of a write are sampled just after the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock);
    addr    <= a;
    wr_data <= v;
    wr_stb  <= 1'b1;
    @(posedge clock);
    wr_stb  <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    v = rd_data;
  endtask

  // Counts puncture-start flags and phase toggles over a run of encoder bits
  task automatic enc_run(input logic [7:0] ctl, input int nbits);
    logic prev;
    ones    = 0;
    toggles = 0;
    prev    = 1'b0;
    wr(8'h02, ctl);
    for (int i = 0; i < nbits; i++)
    begin
      @(posedge clock);
      enc_bit_in    <= i[0];
      enc_bit_valid <= 1'b1;
      @(posedge clock);
      enc_bit_valid <= 1'b0;
      rd(8'h02, d);
      chk("enc_reserved", d[7:4], 16'h0000);
      ones += d[2];
      if (i > 0 && d[3] !== prev)
        toggles++;
      prev = d[3];
    end
  endtask

  initial
  begin
    rst_n = 1'b0;
    addr = 8'h00;
    wr_data = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    enc_bit_in = 1'b0;
    enc_bit_valid = 1'b0;
    ber_result = 16'h0000;
    ber_update = 1'b0;
    phase_sync_en = 1'b0;
    n_errors = 0;
    n_checks = 0;
    rows = '{'{8'h9A, 3'h1, 3'h2, 1'b1, 1'b1}, '{8'h00, 3'h0, 3'h0, 1'b0, 1'b0},
             '{8'h77, 3'h7, 3'h7, 1'b0, 1'b0}, '{8'h80, 3'h0, 3'h0, 1'b1, 1'b0},
             '{8'h08, 3'h0, 3'h0, 1'b0, 1'b1}};
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("rate_reset", rate_enable, 16'h0001);
    chk("serial_reset", serial_mode, 16'h0000);
    // Symbol writes at rate 1/2, one set per row
    foreach (rows[i])
    begin
      wr(8'h00, rows[i].din);
      chk("sym_valid", symbols_valid, 16'h0001);
      chk("soft_first", soft_in_first, rows[i].f);
      chk("soft_second", soft_in_second, rows[i].s);
      chk("erase_first", erase_first, rows[i].e1);
      chk("erase_second", erase_second, rows[i].e2);
    end
    // Each rate enable alone, then serial mode select
    // one rate bit
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h02, 8'h04 << i);
      chk("rate_enable", rate_enable, 16'h0001 << i);
    end
    wr(8'h02, 8'h05);
    chk("serial_mode", serial_mode, 16'h0001);
    wr(8'h02, 8'h04);
    chk("parallel_mode", serial_mode, 16'h0000);
    // Phase ambiguity select needs parallel mode, a qualifying rate and sync on
    // The phase select flop follows control one by one more cycle
    @(posedge clock);
    phase_sync_en <= 1'b1;
    wr(8'h02, 8'h06);
    @(posedge clock);
    #1;
    chk("oqpsk_on", oqpsk_active, 16'h0001);
    wr(8'h02, 8'h04);
    @(posedge clock);
    #1;
    chk("qpsk_sel", oqpsk_active, 16'h0000);
    wr(8'h02, 8'h12);
    @(posedge clock);
    #1;
    chk("oqpsk_r13", oqpsk_active, 16'h0000);
    wr(8'h02, 8'h07);
    @(posedge clock);
    #1;
    chk("oqpsk_serial", oqpsk_active, 16'h0000);
    @(posedge clock);
    phase_sync_en <= 1'b0;
    wr(8'h02, 8'h06);
    @(posedge clock);
    #1;
    chk("oqpsk_nosync", oqpsk_active, 16'h0000);
    // Error rate low byte, read idle, then high byte and unmapped places
    @(posedge clock);
    ber_result <= 16'hA55A;
    ber_update <= 1'b1;
    @(posedge clock);
    ber_update <= 1'b0;
    rd(8'h03, d);
    chk("err_low", d, 16'h005A);
    @(posedge clock);
    #1;
    chk("rd_idle", rd_data, 16'h0000);
    rd(8'h04, d);
    chk("err_high", d, 16'h00A5);
    rd(8'h00, d);
    chk("rd_wo", d, 16'h0000);
    rd(8'h20, d);
    chk("rd_unmapped", d, 16'h0000);
    // Rate 1/3: the set completes only with the third symbol
    wr(8'h02, 8'h10);
    wr(8'h00, 8'h5B);
    chk("valid_early", symbols_valid, 16'h0000);
    wr(8'h01, 8'hE0);
    chk("valid_third", symbols_valid, 16'h0001);
    chk("soft_third", soft_in_third, 16'h0006);
    chk("erase_third", erase_third, 16'h0001);
    chk("sync_r13", punct_sync, 16'h0000);
    // Punctured rates: bit 7 resyncs, third erase from offset one kept low
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h02, i == 0 ? 8'h08 : 8'h20);
      wr(8'h01, 8'h80);
      chk("punct_sync", punct_sync, 16'h0001);
      chk("erase_punct", erase_third, 16'h0000);
      @(posedge clock);
      #1;
      chk("sync_pulse", punct_sync, 16'h0000);
    end
    // Sign-magnitude soft inputs arrive offset binary at the core
    wr(8'h03, 8'h01);
    chk("notation", soft_notation_select, 16'h0001);
    wr(8'h02, 8'h04);
    wr(8'h00, 8'h01);
    chk("sm_first", soft_in_first, 16'h0003);
    chk("sm_second", soft_in_second, 16'h0002);
    wr(8'h00, 8'hD5);
    chk("sm_neg", soft_in_first, 16'h0005);
    wr(8'h03, 8'h00);
    // Whole puncture periods fix the flag count whatever the start phase
    enc_run(8'h08, 6);
    chk("flag_34", ones, 16'h0002);
    chk("phase_par", toggles, 16'h0000);
    enc_run(8'h21, 14);
    chk("flag_78", ones, 16'h0002);
    chk("phase_ser", toggles, 16'h000D);
    // Second reset mid-run clears the encoder state
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("rate_rst2", rate_enable, 16'h0001);
    chk("rd_rst2", rd_data, 16'h0000);
    @(posedge clock);
    rst_n <= 1'b1;
    wr(8'h02, 8'h10);
    @(posedge clock);
    enc_bit_in    <= 1'b1;
    enc_bit_valid <= 1'b1;
    @(posedge clock);
    enc_bit_valid <= 1'b0;
    rd(8'h02, d);
    chk("enc_r13", d[2:0], 16'h0007);
    wr(8'h02, 8'h04);
    rd(8'h02, d);
    chk("enc_r12", d[2:0], 16'h0003);
    tally_and_finish();
  end
endmodule

//--- verilog/fecc_conv_encoder.sv
`timescale 1ns/1ns
`include "fecc_params.svh"

module fecc_conv_encoder
  import fecc_pkg::*;
#(
  parameter int          K_LEN      = 7,
  parameter logic [6:0]  GEN_FIRST  = `FECC_GEN_FIRST,
  parameter logic [6:0]  GEN_SECOND = `FECC_GEN_SECOND,
  parameter logic [6:0]  GEN_THIRD  = `FECC_GEN_THIRD
)
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Mode
  input  wire fecc_pkg::fecc_rate_e rate,
  input  wire logic              serial_mode,
  // Data bit in
  input  wire logic              bit_in,
  input  wire logic              bit_valid,
  // Symbols out
  output logic                   sym_first,
  output logic                   sym_second,
  output logic                   sym_third,
  output logic                   punct_first,
  output logic                   codeword_phase
);

  logic [K_LEN-2:0] shift_reg, shift_next;
  logic [2:0]       sym_reg, sym_next;
  logic [2:0]       phase_cnt_reg, phase_cnt_next;
  logic             punct_reg, punct_next;
  logic             cw_reg, cw_next;
  logic [K_LEN-1:0] window;
  logic [2:0]       period;

  function automatic logic parity_tap(input logic [6:0] w, input logic [6:0] g);
    parity_tap = ^(w & g);
  endfunction

  always_comb
  begin
    window         = {bit_in, shift_reg};
    period         = (rate == FECC_RATE_78) ? 3'(`FECC_PUNCT_LEN_78) : 3'(`FECC_PUNCT_LEN_34);
    shift_next     = shift_reg;
    sym_next       = sym_reg;
    phase_cnt_next = phase_cnt_reg;
    punct_next     = punct_reg;
    cw_next        = cw_reg;
    if (bit_valid)
    begin
      shift_next = window[K_LEN-1:1];
      sym_next   = {parity_tap(window, GEN_THIRD), parity_tap(window, GEN_SECOND),
                    parity_tap(window, GEN_FIRST)};
      // Phase 0 marks the first symbol of the puncture pattern
      punct_next     = (phase_cnt_reg == 3'h0);
      phase_cnt_next = (phase_cnt_reg + 3'h1 >= period) ? 3'h0 : phase_cnt_reg + 3'h1;
      // Serial mode alternates the two code words on one line
      cw_next = serial_mode ? ~cw_reg : 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      shift_reg     <= '0;
      sym_reg       <= 3'h0;
      phase_cnt_reg <= 3'h0;
      punct_reg     <= 1'b0;
      cw_reg        <= 1'b0;
    end
    else
    begin
      shift_reg     <= shift_next;
      sym_reg       <= sym_next;
      phase_cnt_reg <= phase_cnt_next;
      punct_reg     <= punct_next;
      cw_reg        <= cw_next;
    end
  end

  assign sym_first      = sym_reg[0];
  assign sym_second     = sym_reg[1];
  assign sym_third      = sym_reg[2];
  assign punct_first    = punct_reg;
  assign codeword_phase = cw_reg;

endmodule

//--- verilog/fecc_params.svh
`ifndef FECC_PARAMS_SVH
`define FECC_PARAMS_SVH

// Write map
`define FECC_WR_SYMBOL_A      8'h00
`define FECC_WR_SYMBOL_B      8'h01
`define FECC_WR_CONTROL_ONE   8'h02
`define FECC_WR_CONTROL_TWO   8'h03

// Read map
`define FECC_RD_ENC_OUTPUT    8'h02
`define FECC_RD_ERR_LOW       8'h03
`define FECC_RD_ERR_HIGH      8'h04

// Symbol input fields
`define FECC_SYM_LO_POS       0
`define FECC_ERASE_LO_BIT     3
`define FECC_SYM_HI_POS       4
`define FECC_ERASE_HI_BIT     7

// Control one fields, and notation bit of control two
`define FECC_CTL_SERIAL_BIT   0
`define FECC_CTL_OQPSK_BIT    1
`define FECC_CTL_RATE_POS     2
`define FECC_CTL_NOTATION_BIT 0

// Encoder output fields
`define FECC_ENC_THIRD_BIT    2
`define FECC_ENC_PHASE_BIT    3

// Reset values
`define FECC_CTL_ONE_RESET    8'h04
`define FECC_CTL_TWO_RESET    8'h00

// Puncture periods in input bits
`define FECC_PUNCT_LEN_34     3
`define FECC_PUNCT_LEN_78     7

// Generator polynomials, constraint length 7
`define FECC_GEN_FIRST        7'h79
`define FECC_GEN_SECOND       7'h5B
`define FECC_GEN_THIRD        7'h65

`endif

//--- verilog/fecc_pkg.sv
package fecc_pkg;

  typedef enum logic [3:0] {
    FECC_RATE_12 = 4'b0001,
    FECC_RATE_34 = 4'b0010,
    FECC_RATE_13 = 4'b0100,
    FECC_RATE_78 = 4'b1000
  } fecc_rate_e;

  typedef logic [2:0] fecc_soft_t;

endpackage

//--- verilog/fecc_regport.sv
// What this block does
// - Encoder output read shows first, second symbols; third symbol at rate 1/3.
// - At rates 3/4 and 7/8, bit 2 flags first puncture-pattern symbol.
// - In serial mode, bit 3 shows first code word active.
// - Read offset three returns low byte of 16-bit error rate.
// - Read offset four returns high byte of 16-bit error rate.
// - Write offset zero carries second symbol bits 0-2, first symbol bits 4-6.
// - Bit 3 erases second symbol, bit 7 erases first symbol.
// - Write offset one carries third symbol on bits 4-6; bits 0-3 zero.
// - At rate 1/3, bit 7 of offset one erases third symbol.
// - At rates 3/4, 7/8, that bit resynchronises the puncture pattern instead.
// - Control one bit 0 selects serial or parallel input mode.
// - Bit 1 picks OQPSK or QPSK phase resolution in qualifying modes.
// - Control bits 2-5 enable rates 1/2, 3/4, 1/3, 7/8; bits 6-7 zero.
// - Notation bit chooses offset-binary (0) or sign-magnitude (1) soft inputs.
`timescale 1ns/1ns
`include "fecc_params.svh"

module fecc_regport
  import fecc_pkg::*;
(
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  // Register port
  input  wire logic [7:0]           addr,
  input  wire logic [7:0]           wr_data,
  input  wire logic                 wr_stb,
  input  wire logic                 rd_stb,
  output logic      [7:0]           rd_data,
  // Encoder data in
  input  wire logic                 enc_bit_in,
  input  wire logic                 enc_bit_valid,
  // Error rate measurement and phase sync enable from decoder core
  input  wire logic [15:0]          ber_result,
  input  wire logic                 ber_update,
  input  wire logic                 phase_sync_en,
  // Toward decoder core
  output fecc_pkg::fecc_soft_t      soft_in_first,
  output fecc_pkg::fecc_soft_t      soft_in_second,
  output fecc_pkg::fecc_soft_t      soft_in_third,
  output logic                      erase_first,
  output logic                      erase_second,
  output logic                      erase_third,
  output logic                      punct_sync,
  output logic                      symbols_valid,
  output logic                      serial_mode,
  output logic                      oqpsk_active,
  output logic      [3:0]           rate_enable,
  output logic                      soft_notation_select
);

  import fecc_pkg::*;

  // Register state
  logic [7:0]  ctl_one_reg, ctl_one_next;
  logic [7:0]  ctl_two_reg, ctl_two_next;
  logic [15:0] ber_reg, ber_next;
  logic [7:0]  rd_data_reg, rd_data_next;
  // Decoder side state
  fecc_soft_t  soft_a_reg, soft_a_next;
  fecc_soft_t  soft_b_reg, soft_b_next;
  fecc_soft_t  soft_c_reg, soft_c_next;
  logic [2:0]  erase_reg, erase_next;
  logic        sync_reg, sync_next;
  logic        valid_reg, valid_next;
  logic        oqpsk_reg, oqpsk_next;
  // Encoder and decode
  fecc_rate_e  rate;
  logic        enc_sym_first, enc_sym_second, enc_sym_third, enc_punct, enc_phase;
  logic [7:0]  enc_byte;
  logic        punctured;
  logic        wr_a, wr_b;

  // Map a raw symbol to offset binary; sign-magnitude zeros reverse magnitude
  function automatic fecc_soft_t to_offset_binary(input fecc_soft_t s, input logic sm);
    to_offset_binary = (sm && !s[2]) ? {1'b0, ~s[1:0]} : s;
  endfunction

  // Rate select
  always_comb
  begin
    unique case (ctl_one_reg[`FECC_CTL_RATE_POS +: 4])
      4'b0001: rate = FECC_RATE_12;
      4'b0010: rate = FECC_RATE_34;
      4'b0100: rate = FECC_RATE_13;
      4'b1000: rate = FECC_RATE_78;
      // Illegal mixes fall back to rate 1/2 so the datapath stays defined
      default: rate = FECC_RATE_12;
    endcase
  end

  assign punctured = (rate == FECC_RATE_34) || (rate == FECC_RATE_78);
  assign wr_a      = wr_stb && (addr == `FECC_WR_SYMBOL_A);
  assign wr_b      = wr_stb && (addr == `FECC_WR_SYMBOL_B);

  fecc_conv_encoder u_encoder (
    .clock          (clock),
    .rst_n          (rst_n),
    .rate           (rate),
    .serial_mode    (ctl_one_reg[`FECC_CTL_SERIAL_BIT]),
    .bit_in         (enc_bit_in),
    .bit_valid      (enc_bit_valid),
    .sym_first      (enc_sym_first),
    .sym_second     (enc_sym_second),
    .sym_third      (enc_sym_third),
    .punct_first    (enc_punct),
    .codeword_phase (enc_phase)
  );

  always_comb
  begin
    enc_byte = 8'h00;
    enc_byte[0] = enc_sym_first;
    enc_byte[1] = enc_sym_second;
    if (rate == FECC_RATE_13)
    begin
      enc_byte[`FECC_ENC_THIRD_BIT] = enc_sym_third;
    end
    else if (punctured)
    begin
      enc_byte[`FECC_ENC_THIRD_BIT] = enc_punct;
    end
    // code word phase in serial mode
    enc_byte[`FECC_ENC_PHASE_BIT] = ctl_one_reg[`FECC_CTL_SERIAL_BIT] && enc_phase;
  end

  // Control and read path
  always_comb
  begin
    ctl_one_next = ctl_one_reg;
    ctl_two_next = ctl_two_reg;
    ber_next     = ber_reg;
    rd_data_next = 8'h00;
    if (wr_stb && addr == `FECC_WR_CONTROL_ONE)
    begin
      // mode and rate control; bits 6-7 kept zero
      ctl_one_next = {2'b00, wr_data[5:0]};
    end
    if (wr_stb && addr == `FECC_WR_CONTROL_TWO)
    begin
      ctl_two_next = {7'h00, wr_data[`FECC_CTL_NOTATION_BIT]};
    end
    if (ber_update)
    begin
      ber_next = ber_result;
    end
    if (rd_stb)
    begin
      unique case (addr)
        `FECC_RD_ENC_OUTPUT: rd_data_next = enc_byte;
        `FECC_RD_ERR_LOW:    rd_data_next = ber_reg[7:0];
        `FECC_RD_ERR_HIGH:   rd_data_next = ber_reg[15:8];
        default:             rd_data_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_one_reg <= `FECC_CTL_ONE_RESET;
      ctl_two_reg <= `FECC_CTL_TWO_RESET;
      ber_reg     <= 16'h0000;
      rd_data_reg <= 8'h00;
    end
    else
    begin
      ctl_one_reg <= ctl_one_next;
      ctl_two_reg <= ctl_two_next;
      ber_reg     <= ber_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // Decoder symbol path
  always_comb
  begin
    soft_a_next = soft_a_reg;
    soft_b_next = soft_b_reg;
    soft_c_next = soft_c_reg;
    erase_next  = erase_reg;
    sync_next   = 1'b0;
    valid_next  = 1'b0;
    if (wr_a)
    begin
      // two symbols, first input in high nibble
      soft_b_next = to_offset_binary(wr_data[`FECC_SYM_LO_POS +: 3], ctl_two_reg[0]);
      soft_a_next = to_offset_binary(wr_data[`FECC_SYM_HI_POS +: 3], ctl_two_reg[0]);
      erase_next[1] = wr_data[`FECC_ERASE_LO_BIT];
      erase_next[0] = wr_data[`FECC_ERASE_HI_BIT];
      // Rate 1/3 waits for the third symbol before presenting a set
      valid_next = (rate != FECC_RATE_13);
    end
    if (wr_b)
    begin
      soft_c_next = to_offset_binary(wr_data[`FECC_SYM_HI_POS +: 3], ctl_two_reg[0]);
      erase_next[2] = (rate == FECC_RATE_13) && wr_data[`FECC_ERASE_HI_BIT];
      // puncture resync at 3/4 and 7/8
      sync_next  = punctured && wr_data[`FECC_ERASE_HI_BIT];
      valid_next = (rate == FECC_RATE_13);
    end
  end

  always_comb
  begin
    oqpsk_next = !ctl_one_reg[`FECC_CTL_SERIAL_BIT] && (rate != FECC_RATE_13)
                 && phase_sync_en && ctl_one_reg[`FECC_CTL_OQPSK_BIT];
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      soft_a_reg <= 3'h0;
      soft_b_reg <= 3'h0;
      soft_c_reg <= 3'h0;
      erase_reg  <= 3'h0;
      sync_reg   <= 1'b0;
      valid_reg  <= 1'b0;
      oqpsk_reg  <= 1'b0;
    end
    else
    begin
      soft_a_reg <= soft_a_next;
      soft_b_reg <= soft_b_next;
      soft_c_reg <= soft_c_next;
      erase_reg  <= erase_next;
      sync_reg   <= sync_next;
      valid_reg  <= valid_next;
      oqpsk_reg  <= oqpsk_next;
    end
  end

  assign rd_data              = rd_data_reg;
  assign soft_in_first        = soft_a_reg;
  assign soft_in_second       = soft_b_reg;
  assign soft_in_third        = soft_c_reg;
  assign erase_first          = erase_reg[0];
  assign erase_second         = erase_reg[1];
  assign erase_third          = erase_reg[2];
  assign punct_sync           = sync_reg;
  assign symbols_valid        = valid_reg;
  // serial select straight from its flop
  assign serial_mode          = ctl_one_reg[`FECC_CTL_SERIAL_BIT];
  assign oqpsk_active         = oqpsk_reg;
  assign rate_enable          = ctl_one_reg[`FECC_CTL_RATE_POS +: 4];
  assign soft_notation_select = ctl_two_reg[`FECC_CTL_NOTATION_BIT];

  // Checks
  sequence s_read_enc;
    rd_stb && addr == `FECC_RD_ENC_OUTPUT;
  endsequence

  chk_enc_low_bits: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_enc |=> rd_data[1:0] == $past({enc_sym_second, enc_sym_first}))
    else $error("encoder symbols misplaced in read data");

  chk_punct_flag: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_enc ##0 punctured |=> rd_data[2] == $past(enc_punct))
    else $error("puncture start flag wrong");

  chk_phase_bit: assert property (
    @(posedge clock) disable iff (!rst_n)
    s_read_enc ##0 !serial_mode |=> !rd_data[3])
    else $error("code word phase shown outside serial mode");

  chk_ber_low: assert property (
    @(posedge clock) disable iff (!rst_n)
    rd_stb && addr == `FECC_RD_ERR_LOW |=> rd_data == $past(ber_reg[7:0]))
    else $error("error rate low byte wrong");

  chk_ber_high: assert property (
    @(posedge clock) disable iff (!rst_n)
    rd_stb && addr == `FECC_RD_ERR_HIGH |=> rd_data == $past(ber_reg[15:8]))
    else $error("error rate high byte wrong");

  chk_erase_pair: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_a |=> erase_second == $past(wr_data[3]) && erase_first == $past(wr_data[7]))
    else $error("erase flags not taken");

  chk_third_erase: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_b && wr_data[7] && rate == FECC_RATE_13 |=> erase_third && !punct_sync)
    else $error("third erase not applied");

  chk_sync_pulse: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_b && wr_data[7] && punctured |=> punct_sync && !erase_third
      ##1 (!punct_sync || $past(wr_b && wr_data[7])))
    else $error("puncture sync pulse wrong");

  chk_rate_write: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_stb && addr == `FECC_WR_CONTROL_ONE |=> rate_enable == $past(wr_data[5:2]))
    else $error("rate enables not written");

  chk_oqpsk_gate: assert property (
    @(posedge clock) disable iff (!rst_n)
    serial_mode || !phase_sync_en |=> !oqpsk_active)
    else $error("phase mode active when not qualified");

  chk_notation: assert property (
    @(posedge clock) disable iff (!rst_n)
    wr_a && soft_notation_select && wr_data[6:4] == 3'h0 |=> soft_in_first == 3'h3)
    else $error("sign-magnitude weakest zero not mapped");

endmodule
